// ### hw/rbd_regs.svh
`ifndef RBD_REGS_SVH
`define RBD_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RBD_OFF_CTRL     8'h00
`define RBD_OFF_CMD      8'h04
`define RBD_OFF_BANK     8'h08
`define RBD_OFF_WREG     8'h0C
`define RBD_OFF_STATUS   8'h10
`define RBD_OFF_INDEX    8'h14
`define RBD_OFF_EADDR    8'h18
`define RBD_OFF_RESULT   8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define RBD_CTRL_EXT     0
`define RBD_CMD_D        8
`define RBD_CMD_A        9
`define RBD_CMD_OP       10
`define RBD_ST_C         0
`define RBD_ST_Z         2
`define RBD_ST_N         4
`define RBD_ST_BUSY      8

// ----------------------------------------
// reset values and address constants
// ----------------------------------------
`define RBD_RST_CTRL     1'b0
`define RBD_RST_BANK     4'h0
`define RBD_RST_BYTE     8'h00
`define RBD_RST_INDEX    12'h000
`define RBD_RST_ADDR     12'h000
`define RBD_LIT_LIMIT    8'h5F
`define RBD_SFR_PAGE     4'hF
`define RBD_LOW_PAGE     4'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define RBD_EXEC_NS      10
`define RBD_CLK_NS       10
`define RBD_EXEC_CYC     (`RBD_EXEC_NS / `RBD_CLK_NS)

`endif

// ### hw/rbd_pkg.sv
`default_nettype none
package rbd_pkg;

  typedef enum logic [2:0] {
    RBD_IDLE  = 3'b001,
    RBD_EXEC  = 3'b010,
    RBD_WBACK = 3'b100
  } rbd_state_t;

  typedef enum logic {
    RBD_ROTATE_LEFT_PLAIN      = 1'b0,
    RBD_ROTATE_RIGHT_VIA_CARRY = 1'b1
  } rbd_op_t;

endpackage

`default_nettype wire

// ### hw/rbd_rotate_bit_datapath.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbd_regs.svh"

module rbd_rotate_bit_datapath (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [11:0] fr_addr,
  input  wire logic [7:0]  fr_rdata,
  output logic             fr_we,
  output logic      [7:0]  fr_wdata
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  rbd_pkg::rbd_state_t state;
  rbd_pkg::rbd_state_t next_state;

  logic        ext_en;
  logic [3:0]  bank_pointer_register;
  logic [7:0]  wreg;
  logic        flag_c;
  logic        flag_z;
  logic        flag_n;
  logic [11:0] index_base;
  logic [7:0]  cmd_f;
  logic        cmd_d;
  logic        cmd_a;
  rbd_pkg::rbd_op_t cmd_op;
  logic [7:0]  result;

  logic        bus_req;
  logic        bus_wr;
  logic        cmd_go;
  logic [7:0]  rotate_left_plain;
  logic [7:0]  rotate_right_via_carry;
  logic [7:0]  next_result;
  logic        next_c;
  logic [31:0] next_rdata;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr == off);
  endfunction

  function automatic logic [11:0] eff_addr(
    input logic [7:0]  f,
    input logic        a,
    input logic [3:0]  bank,
    input logic        ext,
    input logic [11:0] base
  );
    logic [11:0] addr;
    addr = `RBD_RST_ADDR;
    if (a) begin
      addr = {bank, f};
    end else if (ext && (f <= `RBD_LIT_LIMIT)) begin
      addr = 12'(base + {4'h0, f});
    end else if (f <= `RBD_LIT_LIMIT) begin
      addr = {`RBD_LOW_PAGE, f};
    end else begin
      addr = {`RBD_SFR_PAGE, f};
    end
    eff_addr = addr;
  endfunction

  // ----------------------------------------
  // bus request decode
  // ----------------------------------------
  // one answer per request: ack is held off in the cycle it is high
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;
  // a command written while busy is dropped, not queued
  assign cmd_go  = bus_wr & reg_hit(wb_adr_i, `RBD_OFF_CMD) & (state == rbd_pkg::RBD_IDLE)
                   & wb_sel_i[0] & wb_sel_i[1];

  // ----------------------------------------
  // rotate datapath
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 1; gi < 8; gi = gi + 1) begin : g_rot
      assign rotate_left_plain[gi]          = fr_rdata[gi - 1];
      assign rotate_right_via_carry[gi - 1] = fr_rdata[gi];
    end
  endgenerate
  assign rotate_left_plain[0]      = fr_rdata[7];
  assign rotate_right_via_carry[7] = flag_c;

  always_comb begin
    next_result = rotate_left_plain;
    next_c      = flag_c;
    case (cmd_op)
      rbd_pkg::RBD_ROTATE_LEFT_PLAIN: begin
        next_result = rotate_left_plain;
        next_c      = flag_c;
      end
      rbd_pkg::RBD_ROTATE_RIGHT_VIA_CARRY: begin
        next_result = rotate_right_via_carry;
        next_c      = fr_rdata[0];
      end
      default: begin
        next_result = rotate_left_plain;
        next_c      = flag_c;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      rbd_pkg::RBD_IDLE: begin
        if (cmd_go) begin
          next_state = rbd_pkg::RBD_EXEC;
        end
      end
      rbd_pkg::RBD_EXEC: begin
        next_state = cmd_d ? rbd_pkg::RBD_WBACK : rbd_pkg::RBD_IDLE;
      end
      rbd_pkg::RBD_WBACK: begin
        next_state = rbd_pkg::RBD_IDLE;
      end
      default: begin
        next_state = rbd_pkg::RBD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rbd_pkg::RBD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // command latch and file address
  // ----------------------------------------
  // address is frozen at issue so a bank change mid-op cannot tear it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_f   <= `RBD_RST_BYTE;
      cmd_d   <= 1'b0;
      cmd_a   <= 1'b0;
      cmd_op  <= rbd_pkg::RBD_ROTATE_LEFT_PLAIN;
      fr_addr <= `RBD_RST_ADDR;
    end else if (cmd_go) begin
      cmd_f   <= wb_dat_i[7:0];
      cmd_d   <= wb_dat_i[`RBD_CMD_D];
      cmd_a   <= wb_dat_i[`RBD_CMD_A];
      cmd_op  <= rbd_pkg::rbd_op_t'(wb_dat_i[`RBD_CMD_OP]);
      fr_addr <= eff_addr(wb_dat_i[7:0], wb_dat_i[`RBD_CMD_A], bank_pointer_register,
                          ext_en, index_base);
    end
  end

  // ----------------------------------------
  // result and write-back
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= `RBD_RST_BYTE;
    end else if (state == rbd_pkg::RBD_EXEC) begin
      result <= next_result;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_we    <= 1'b0;
      fr_wdata <= `RBD_RST_BYTE;
    end else begin
      fr_we <= (state == rbd_pkg::RBD_EXEC) & cmd_d;
      if (state == rbd_pkg::RBD_EXEC) begin
        fr_wdata <= next_result;
      end
    end
  end

  // ----------------------------------------
  // accumulator: execution beats a same-cycle bus write
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wreg <= `RBD_RST_BYTE;
    end else if ((state == rbd_pkg::RBD_EXEC) && !cmd_d) begin
      wreg <= next_result;
    end else if (bus_wr && reg_hit(wb_adr_i, `RBD_OFF_WREG) && wb_sel_i[0]) begin
      wreg <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_c <= 1'b0;
      flag_z <= 1'b0;
      flag_n <= 1'b0;
    end else if (state == rbd_pkg::RBD_EXEC) begin
      flag_c <= next_c;
      flag_z <= (next_result == `RBD_RST_BYTE);
      flag_n <= next_result[7];
    end else if (bus_wr && reg_hit(wb_adr_i, `RBD_OFF_STATUS) && wb_sel_i[0]) begin
      flag_c <= wb_dat_i[`RBD_ST_C];
      flag_z <= wb_dat_i[`RBD_ST_Z];
      flag_n <= wb_dat_i[`RBD_ST_N];
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_en <= `RBD_RST_CTRL;
    end else if (bus_wr && reg_hit(wb_adr_i, `RBD_OFF_CTRL) && wb_sel_i[0]) begin
      ext_en <= wb_dat_i[`RBD_CTRL_EXT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_pointer_register <= `RBD_RST_BANK;
    end else if (bus_wr && reg_hit(wb_adr_i, `RBD_OFF_BANK) && wb_sel_i[0]) begin
      bank_pointer_register <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_base <= `RBD_RST_INDEX;
    end else if (bus_wr && reg_hit(wb_adr_i, `RBD_OFF_INDEX)) begin
      if (wb_sel_i[0]) begin
        index_base[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        index_base[11:8] <= wb_dat_i[11:8];
      end
    end
  end

  // ----------------------------------------
  // bus read and acknowledge
  // ----------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `RBD_OFF_CTRL:   next_rdata[`RBD_CTRL_EXT] = ext_en;
      `RBD_OFF_CMD:    next_rdata[10:0] = {cmd_op, cmd_a, cmd_d, cmd_f};
      `RBD_OFF_BANK:   next_rdata[3:0] = bank_pointer_register;
      `RBD_OFF_WREG:   next_rdata[7:0] = wreg;
      `RBD_OFF_STATUS: begin
        next_rdata[`RBD_ST_C]    = flag_c;
        next_rdata[`RBD_ST_Z]    = flag_z;
        next_rdata[`RBD_ST_N]    = flag_n;
        next_rdata[`RBD_ST_BUSY] = (state != rbd_pkg::RBD_IDLE);
      end
      `RBD_OFF_INDEX:  next_rdata[11:0] = index_base;
      `RBD_OFF_EADDR:  next_rdata[11:0] = fr_addr;
      `RBD_OFF_RESULT: next_rdata[7:0] = result;
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // unmapped offsets still ack, reading zero, so a stray access never hangs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule

`default_nettype wire

// ### verification/rbd_rotate_bit_datapath_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rbd_rotate_bit_datapath_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [11:0] fr_addr,
  input wire logic [7:0]  fr_rdata,
  input wire logic        fr_we,
  input wire logic [7:0]  fr_wdata
);
  // ----
  // shadows of the address registers
  // ----
  // busy window mirrors the sequencer so a refused command is never checked
  logic        bus_wr;
  logic        cmd_take;
  logic        shadow_ext;
  logic [3:0]  shadow_bank;
  logic [11:0] shadow_index;
  logic [7:0]  shadow_f;
  logic [7:0]  prev_rdata;
  logic [1:0]  busy_left;
  assign bus_wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign cmd_take = bus_wr && wb_sel_i[0] && wb_sel_i[1] && wb_adr_i == 8'h04 && busy_left == 2'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_ext   <= 1'b0;
      shadow_bank  <= 4'h0;
      shadow_index <= 12'h000;
      shadow_f     <= 8'h00;
      prev_rdata   <= 8'h00;
      busy_left    <= 2'h0;
    end else begin
      prev_rdata <= fr_rdata;
      if (bus_wr && wb_sel_i[0] && wb_adr_i == 8'h00) shadow_ext <= wb_dat_i[0];
      if (bus_wr && wb_sel_i[0] && wb_adr_i == 8'h08) shadow_bank <= wb_dat_i[3:0];
      if (bus_wr && wb_sel_i[0] && wb_adr_i == 8'h14) shadow_index[7:0] <= wb_dat_i[7:0];
      if (bus_wr && wb_sel_i[1] && wb_adr_i == 8'h14) shadow_index[11:8] <= wb_dat_i[11:8];
      if (cmd_take) shadow_f <= wb_dat_i[7:0];
      if (cmd_take) busy_left <= wb_dat_i[8] ? 2'h2 : 2'h1;
      else if (busy_left != 2'h0) busy_left <= busy_left - 2'h1;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");
  a_bank_addr: assert property (cmd_take && wb_dat_i[9] |=> fr_addr == {shadow_bank, shadow_f})
    else $error("banked address wrong");
  a_access_low: assert property (cmd_take && !wb_dat_i[9] && !shadow_ext && wb_dat_i[7:0] <= 8'h5F
    |=> fr_addr == {4'h0, shadow_f})
    else $error("low access address wrong");
  a_access_high: assert property (cmd_take && !wb_dat_i[9] && wb_dat_i[7:0] > 8'h5F
    |=> fr_addr == {4'hF, shadow_f})
    else $error("high access address wrong");
  a_index_offset: assert property (cmd_take && !wb_dat_i[9] && shadow_ext && wb_dat_i[7:0] <= 8'h5F
    |=> fr_addr == shadow_index + 12'(shadow_f))
    else $error("indexed address wrong");
  a_dest_file: assert property (cmd_take && wb_dat_i[8] |=> !fr_we ##1 fr_we ##1 !fr_we)
    else $error("file write pulse wrong");
  a_dest_accum: assert property (cmd_take && !wb_dat_i[8] |=> !fr_we [*3])
    else $error("file written for accumulator target");
  a_left_result: assert property (cmd_take && wb_dat_i[8] && !wb_dat_i[10]
    |=> ##1 fr_wdata == {prev_rdata[6:0], prev_rdata[7]})
    else $error("left rotate result wrong");
  a_right_shift: assert property (cmd_take && wb_dat_i[8] && wb_dat_i[10]
    |=> ##1 fr_wdata[6:0] == prev_rdata[7:1])
    else $error("right rotate result wrong");
endmodule
bind rbd_rotate_bit_datapath rbd_rotate_bit_datapath_asserts rbd_rotate_bit_datapath_asserts_i (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .fr_addr, .fr_rdata, .fr_we, .fr_wdata
);
`default_nettype wire

// ### verification/rbd_rotate_bit_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rbd_rotate_bit_datapath_tb;
  logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fr_we;
  logic [7:0]  wb_adr_i, fr_rdata, fr_wdata;
  logic [7:0]  wr_seen = 8'h00;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [11:0] fr_addr;
  int          err_count;
  int          checks;
  // ----
  // tables
  // ----
  logic [7:0]  t_fr [5] = '{8'hAB, 8'h80, 8'h56, 8'h01, 8'h00};
  logic [7:0]  t_res [5] = '{8'h57, 8'h01, 8'hAB, 8'h00, 8'h00};
  logic [7:0]  t_st [5] = '{8'h00, 8'h01, 8'h10, 8'h05, 8'h04};
  logic [4:0]  t_c = 5'h06;
  logic [4:0]  t_op = 5'h0C;
  logic [4:0]  t_d = 5'h15;
  logic [7:0]  t_f [6] = '{8'h33, 8'h5F, 8'h60, 8'h5F, 8'h00, 8'h10};
  logic [11:0] t_ea [6] = '{12'h533, 12'h05F, 12'hF60, 12'h01F, 12'hFC0, 12'h510};
  logic [5:0]  t_a = 6'h21;
  logic [5:0]  t_x = 6'h38;
  rbd_rotate_bit_datapath rbd_rotate_bit_datapath_i (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .fr_addr, .fr_rdata, .fr_we, .fr_wdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (fr_we === 1'b1) wr_seen <= fr_wdata;
  // ----
  // tasks
  // ----
  task automatic final_report();
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // no ack within the bound ends the run
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int i;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 20) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    bus(1'b1, adr, dat, d);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 32'h0000_0000, d);
    check(d, exp);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    fr_rdata = 8'h00;
    err_count = 0;
    checks = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wr(8'h20, 32'hFFFF_FFFF);
    wr(8'h18, 32'hFFFF_FFFF);
    for (int i = 0; i < 9; i++) rd_chk(8'(i * 4), 32'h0000_0000);
    wr(8'h08, 32'h0000_0005);
    wr(8'h14, 32'h0000_0FC0);
    for (int i = 0; i < 5; i++) begin
      fr_rdata <= t_fr[i];
      wr(8'h10, {31'h0000_0000, t_c[i]});
      wr(8'h04, {21'h00_0000, t_op[i], 1'b0, t_d[i], 8'h20});
      rd_chk(8'h1C, {24'h00_0000, t_res[i]});
      rd_chk(8'h10, {24'h00_0000, t_st[i]});
      if (t_d[i]) check({24'h00_0000, wr_seen}, {24'h00_0000, t_res[i]});
      else rd_chk(8'h0C, {24'h00_0000, t_res[i]});
    end
    wr(8'h10, 32'h0000_0115);
    rd_chk(8'h10, 32'h0000_0015);
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, {31'h0000_0000, t_x[i]});
      wr(8'h04, {22'h00_0000, t_a[i], 1'b0, t_f[i]});
      rd_chk(8'h18, {20'h0_0000, t_ea[i]});
      rd_chk(8'h04, {21'h00_0000, 1'b0, t_a[i], 1'b0, t_f[i]});
    end
    final_report();
  end
endmodule
`default_nettype wire
